// ==== src/i2csb_pkg.sv ====
// Shared constants and types of the two-wire bus start, baud and status unit
package i2csb_pkg;

	// ==========================================
	// Widths
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int BAUD_W = 9;
	localparam int BYTE_W = 8;

	// ==========================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_STAT = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_BAUD = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_TXH = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_RXH = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_OWN = 3'h5;

	// ==========================================
	// Control fields
	localparam int BIT_ON = 15;
	localparam int BIT_GCEN = 7;
	localparam int BIT_START = 0;
	localparam logic [DATA_W-1:0] CTRL_RST = 16'h1000;
	localparam logic [DATA_W-1:0] CTRL_WMASK = 16'hbfff;

	// ==========================================
	// Status fields
	localparam int BIT_CLASH = 7;
	localparam int BIT_STOP = 4;
	localparam int BIT_SEEN = 3;
	localparam int BIT_RW = 2;
	localparam int BIT_RXF = 1;
	localparam int BIT_TXF = 0;

	// ==========================================
	// Reset values and counts
	localparam logic [BAUD_W-1:0] BAUD_RST = 9'h001;
	localparam logic [6:0] OWN_RST = 7'h00;
	localparam logic [6:0] GCALL_ADDR = 7'h00;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// ==========================================
	// Start sequencer states
	typedef enum logic [2:0] {
		MS_IDLE = 3'h1,
		MS_SDA = 3'h2,
		MS_SCL = 3'h4
	} i2csb_mst_type;

endpackage

// ==== src/i2csb_sync.sv ====
// Two flip-flop synchroniser for one pin input
module i2csb_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Pin and result
	input wire logic pin,
	output logic q
);
	logic meta;

	// Resets high so an idle bus line reads released
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b1;
			q <= 1'b1;
		end else begin
			meta <= pin;
			q <= meta;
		end
	end
endmodule // i2csb_sync

// ==== src/i2csb_top.sv ====
// Start generator, baud counter and low status bits of the two-wire bus unit
// Overview of operation
// - Stop flag set by Stop, cleared by Start
// - Start flag set by Start, cleared by Stop
// - Slave direction flag taken from address byte
// - Receive full set on load, cleared on read
// - Transmit full set on write, cleared when sent
// - Control bit 15 enables master and slave
// - Enable releases lines; master idle, slave monitors
// - Slave transaction needs Start then matching address
// - Enabled unit owns pins; released when off
// - Master event pulse on sequence completions
// - Slave event pulse on address and bytes
// - Baud counter loads, counts to zero, holds
// - Baud counter reloads while clock line held low
// - Bit time is two baud intervals
// - Transmit write during busy discarded, clash set
// - Request bits locked while Start runs
// - Start request counts, then drives data low
// - Second timeout drives clock low, ends Start
// - Own Start sets start flag, clears stop
// - Clash flag stays until software clears it
module i2csb_top
	import i2csb_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Bus pins
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Links to the byte and sequence logic
	output logic [DATA_W-1:0] control_reg,
	output logic [BYTE_W-1:0] tx_holding_reg,
	output logic tx_start,
	input wire logic tx_done,
	input wire logic tx_busy,
	input wire logic rx_load,
	input wire logic [BYTE_W-1:0] rx_byte_in,
	input wire logic [3:0] seq_done,
	input wire logic bus_collision,
	// Event pulses
	output logic master_event_irq,
	output logic slave_event_irq
);

	// ==========================================
	// Pin synchronisers
	logic sda_s;
	logic scl_s;
	logic sda_q;
	logic scl_q;

	i2csb_sync u_sda_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin(sda_in),
		.q(sda_s)
	);

	i2csb_sync u_scl_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin(scl_in),
		.q(scl_s)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sda_q <= 1'b1;
			scl_q <= 1'b1;
		end else begin
			sda_q <= sda_s;
			scl_q <= scl_s;
		end
	end

	// ==========================================
	// State declarations
	i2csb_mst_type mst;
	i2csb_mst_type next_mst;
	logic [BAUD_W-1:0] baud_reload_reg;
	logic [BAUD_W-1:0] baud_cnt;
	logic [BYTE_W-1:0] rx_holding_reg;
	logic [6:0] own_addr;
	logic [6:0] shift;
	logic [3:0] bit_cnt;
	logic stop_seen;
	logic start_seen;
	logic slave_rw;
	logic rx_full_flag;
	logic tx_full_flag;
	logic write_clash_flag;
	logic in_frame;
	logic addr_phase;
	logic slave_act;

	// ==========================================
	// Register decode
	wire module_on = control_reg[BIT_ON];
	wire ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);
	wire stat_wr = reg_wr && (reg_addr == OFS_STAT);
	wire baud_wr = reg_wr && (reg_addr == OFS_BAUD);
	wire tx_wr = reg_wr && (reg_addr == OFS_TXH);
	wire own_wr = reg_wr && (reg_addr == OFS_OWN);
	wire rx_rd = reg_rd && (reg_addr == OFS_RXH);
	wire start_busy = (mst != MS_IDLE);

	// No queueing: a write that finds the unit busy is dropped, not held
	wire tx_reject = tx_wr && (start_busy || tx_busy);
	wire tx_accept = tx_wr && !tx_reject;

	// ==========================================
	// Start sequencer steps
	wire baud_zero = (baud_cnt == '0);
	wire sda_step = module_on && (mst == MS_SDA) && scl_s && baud_zero;
	wire scl_step = (mst == MS_SCL) && scl_s && baud_zero;
	wire start_clr = scl_step || !module_on;

	// Self-clearing request bits; a write in the same cycle wins unless Start runs, then the clear wins
	wire [DATA_W-1:0] hc_clr = {11'h000, seq_done, start_clr};
	wire [DATA_W-1:0] ctrl_keep = control_reg & ~hc_clr;
	wire [DATA_W-1:0] ctrl_wval = reg_wdata & CTRL_WMASK;
	wire [DATA_W-1:0] ctrl_w = start_busy ?
		{ctrl_wval[15:5], ctrl_keep[4:0]} : ctrl_wval;
	wire [DATA_W-1:0] next_ctrl = ctrl_wr ? ctrl_w : ctrl_keep;
	wire sen_go = ctrl_wr && !start_busy && ctrl_wval[BIT_ON]
		&& ctrl_wval[BIT_START];
	wire req_go = ctrl_wr && !start_busy && (ctrl_wval[4:1] != 4'h0);

	// ==========================================
	// Baud counter
	// A held-low clock line keeps reloading, so timing restarts on release
	wire baud_load = sen_go || (start_busy && (!scl_s || baud_zero));
	wire [BAUD_W-1:0] next_baud = baud_load ? baud_reload_reg :
		(baud_zero ? baud_cnt : baud_cnt - 1'b1);

	always_comb begin
		case (mst)
			MS_IDLE: next_mst = sen_go ? MS_SDA : MS_IDLE;
			MS_SDA: next_mst = !module_on ? MS_IDLE : (sda_step ? MS_SCL : MS_SDA);
			MS_SCL: next_mst = start_clr ? MS_IDLE : MS_SCL;
			default: next_mst = MS_IDLE;
		endcase
	end

	// ==========================================
	// Pin drive
	// Lines stay low after Start until the next request hands them over
	wire release_hold = tx_accept || req_go || sen_go;
	wire next_sda_oe = module_on && (sda_step || (sda_oe && !release_hold));
	wire next_scl_oe = module_on && (scl_step || (scl_oe && !release_hold));

	// ==========================================
	// Bus condition and slave monitor
	wire start_cond = module_on && scl_s && scl_q && sda_q && !sda_s;
	wire stop_cond = module_on && scl_s && scl_q && !sda_q && sda_s;
	wire scl_rise = module_on && in_frame && scl_s && !scl_q;
	wire byte_done = scl_rise && (bit_cnt == BIT_LAST);
	wire [BYTE_W-1:0] got_byte = {shift, sda_s};
	wire addr_match = (got_byte[7:1] == own_addr)
		|| (control_reg[BIT_GCEN] && (got_byte[7:1] == GCALL_ADDR));
	wire addr_hit = byte_done && addr_phase && addr_match;
	wire data_hit = byte_done && !addr_phase && slave_act;
	wire slv_rx = addr_hit || (data_hit && !slave_rw);
	wire rx_set = slv_rx || rx_load;
	wire [3:0] next_bit = start_cond ? 4'h0 :
		(!scl_rise ? bit_cnt : ((bit_cnt == BIT_ACK) ? 4'h0 : bit_cnt + 4'h1));

	// ==========================================
	// Status flags; hardware set wins over any clear
	wire next_rxf = rx_set || (rx_full_flag && !rx_rd);
	wire next_txf = tx_accept || (tx_full_flag && !tx_done);
	wire clash_clr = stat_wr && !reg_wdata[BIT_CLASH];
	wire next_clash = tx_reject || (write_clash_flag && !clash_clr);
	wire next_mirq = scl_step || (seq_done != 4'h0) || bus_collision;
	wire next_sirq = addr_hit || data_hit;

	// ==========================================
	// Read mux
	wire [DATA_W-1:0] stat_word = {8'h00, write_clash_flag, 2'h0, stop_seen,
		start_seen, slave_rw, rx_full_flag, tx_full_flag};
	wire [DATA_W-1:0] rd_mux =
		(reg_addr == OFS_CTRL) ? control_reg :
		(reg_addr == OFS_STAT) ? stat_word :
		(reg_addr == OFS_BAUD) ? {7'h00, baud_reload_reg} :
		(reg_addr == OFS_TXH) ? {8'h00, tx_holding_reg} :
		(reg_addr == OFS_RXH) ? {8'h00, rx_holding_reg} :
		(reg_addr == OFS_OWN) ? {9'h000, own_addr} : 16'h0000;

	// ==========================================
	// Software registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= CTRL_RST;
			baud_reload_reg <= BAUD_RST;
			own_addr <= OWN_RST;
			tx_holding_reg <= 8'h00;
			reg_rdata <= 16'h0000;
		end else begin
			control_reg <= next_ctrl;
			if (baud_wr)
				baud_reload_reg <= reg_wdata[BAUD_W-1:0];
			if (own_wr)
				own_addr <= reg_wdata[6:0];
			if (tx_accept)
				tx_holding_reg <= reg_wdata[BYTE_W-1:0];
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ==========================================
	// Start sequencer and pins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mst <= MS_IDLE;
			baud_cnt <= '0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			tx_start <= 1'b0;
			master_event_irq <= 1'b0;
		end else begin
			mst <= next_mst;
			baud_cnt <= next_baud;
			sda_oe <= next_sda_oe;
			scl_oe <= next_scl_oe;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			tx_start <= tx_accept;
			master_event_irq <= next_mirq;
		end
	end

	// ==========================================
	// Bus condition flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stop_seen <= 1'b0;
			start_seen <= 1'b0;
		end else if (start_cond) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
		end else if (stop_cond) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b1;
		end
	end

	// ==========================================
	// Slave address and byte tracking
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			in_frame <= 1'b0;
			addr_phase <= 1'b0;
			slave_act <= 1'b0;
			slave_rw <= 1'b0;
			bit_cnt <= 4'h0;
			shift <= 7'h00;
		end else begin
			bit_cnt <= next_bit;
			if (scl_rise)
				shift <= got_byte[6:0];
			if (start_cond || stop_cond || !module_on) begin
				in_frame <= start_cond;
				addr_phase <= start_cond;
				slave_act <= 1'b0;
			end else if (byte_done && addr_phase) begin
				addr_phase <= 1'b0;
				slave_act <= addr_match;
			end
			if (addr_hit)
				slave_rw <= got_byte[0];
		end
	end

	// ==========================================
	// Holding flags and slave events
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_full_flag <= 1'b0;
			tx_full_flag <= 1'b0;
			write_clash_flag <= 1'b0;
			rx_holding_reg <= 8'h00;
			slave_event_irq <= 1'b0;
		end else begin
			rx_full_flag <= next_rxf;
			tx_full_flag <= next_txf;
			write_clash_flag <= next_clash;
			if (rx_set)
				rx_holding_reg <= slv_rx ? got_byte : rx_byte_in;
			slave_event_irq <= next_sirq;
		end
	end

	// ==========================================
	// Assertions
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_START_FLAGS: assert property (start_cond |=> start_seen && !stop_seen)
		else $error("start flags wrong after Start");
	AST_STOP_FLAGS: assert property (stop_cond && !start_cond |=> stop_seen && !start_seen)
		else $error("stop flags wrong after Stop");
	AST_DIR: assert property (addr_hit |=> slave_rw == $past(sda_s) && slave_event_irq)
		else $error("direction not taken from address byte");
	AST_RXF: assert property (rx_rd && !rx_set ##1 !rx_set |-> !rx_full_flag)
		else $error("receive full not cleared by read");
	AST_TXF: assert property (tx_accept |=> tx_full_flag && tx_start)
		else $error("transmit full not set on write");
	AST_OFF: assert property (!module_on && !sen_go |=> !sda_oe && !scl_oe && mst == MS_IDLE)
		else $error("lines driven while disabled");
	AST_CLASH: assert property (tx_reject |=> write_clash_flag
		&& tx_holding_reg == $past(tx_holding_reg))
		else $error("busy transmit write not discarded");
	AST_LOCK: assert property (ctrl_wr && start_busy && module_on && !scl_step && seq_done == 4'h0
		|=> control_reg[0] && control_reg[4:1] == $past(control_reg[4:1]))
		else $error("request bits changed during Start");
	AST_BAUD: assert property (mst == MS_IDLE && !sen_go && baud_zero |=> baud_zero)
		else $error("baud counter left zero without reload");
	AST_SYNC: assert property (start_busy && !scl_s |=> baud_cnt == $past(baud_reload_reg))
		else $error("baud not reloaded while clock held");
	AST_SDA: assert property (sda_step |=> sda_oe && !scl_oe && mst == MS_SCL)
		else $error("data line not driven at first timeout");
	AST_SCL: assert property (scl_step && module_on |=> scl_oe && sda_oe
		&& master_event_irq && !control_reg[BIT_START])
		else $error("Start did not end correctly");
	AST_SLV: assert property (byte_done && !addr_phase && slave_act |=> slave_event_irq)
		else $error("slave byte event missing");
endmodule // i2csb_top

// ==== bench/i2csb_peer.sv ====
// Far-side bus master model with pull-ups on both lines
module i2csb_peer (
	// Unit drive
	input wire logic sda_oe,
	input wire logic scl_oe,
	// Resolved lines
	output logic sda_line,
	output logic scl_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sda_low = 1'b0;
	logic scl_low = 1'b0;
	// ==========================================
	// Wired-AND: a released line is pulled high, never left at a stale value
	assign sda_line = ~(sda_oe | sda_low);
	assign scl_line = ~(scl_oe | scl_low);
	// ==========================================
	// Bus conditions on an 80 ns link clock that stands still between frames
	task automatic start_cond();
		sda_low = 1'b1;
		#40;
		scl_low = 1'b1;
		#40;
	endtask
	task automatic stop_cond();
		sda_low = 1'b1;
		#20;
		scl_low = 1'b0;
		#40;
		sda_low = 1'b0;
		#40;
	endtask
	// Eight data clocks then a ninth with data released for the acknowledge
	task automatic send_byte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			sda_low = (i > 0) ? ~b[i-1] : 1'b0;
			#20;
			scl_low = 1'b0;
			#40;
			scl_low = 1'b1;
			#20;
		end
	endtask
endmodule // i2csb_peer

// ==== bench/testbench.sv ====
// Self-checking bench of the start, baud and status unit
module testbench;
	import i2csb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 3'h0;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic sda_out, sda_oe, scl_out, scl_oe, sda_line, scl_line, tx_start;
	logic [DATA_W-1:0] control_reg;
	logic [BYTE_W-1:0] tx_holding_reg;
	logic tx_done = 1'b0;
	logic tx_busy = 1'b0;
	logic rx_load = 1'b0;
	logic [BYTE_W-1:0] rx_byte_in = 8'h00;
	logic [3:0] seq_done = 4'h0;
	logic bus_collision = 1'b0;
	logic master_event_irq, slave_event_irq;
	int n_errors = 0;
	int n_compared = 0;
	int n_mirq = 0;
	int n_sirq = 0;
	int cyc = 0;
	int m0, t;
	logic [7:0] abyte [4] = '{8'h55, 8'h54, 8'h56, 8'h00};
	logic [7:0] rxexp [4] = '{8'h55, 8'hc3, 8'h00, 8'hc3};
	int aexp [4] = '{2, 2, 0, 2};

	// ==========================================
	// Clock, event counters and hang limit
	initial begin
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		n_mirq += (master_event_irq === 1'b1);
		n_sirq += (slave_event_irq === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	i2csb_peer u_peer (.sda_oe(sda_oe), .scl_oe(scl_oe), .sda_line(sda_line),
		.scl_line(scl_line));
	i2csb_top DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_line), .scl_out(scl_out),
		.scl_oe(scl_oe), .control_reg(control_reg), .tx_holding_reg(tx_holding_reg),
		.tx_start(tx_start), .tx_done(tx_done), .tx_busy(tx_busy), .rx_load(rx_load),
		.rx_byte_in(rx_byte_in), .seq_done(seq_done), .bus_collision(bus_collision),
		.master_event_irq(master_event_irq), .slave_event_irq(slave_event_irq));

	// ==========================================
	// Register port tasks and comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e,
		input string what);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, e, what);
	endtask
	task automatic pulse(input int k);
		@(posedge mclk);
		if (k < 4) seq_done <= 4'h1 << k;
		else bus_collision <= 1'b1;
		@(posedge mclk);
		seq_done <= 4'h0;
		bus_collision <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================
	// Tests
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		rdc(OFS_CTRL, 16'hffff, CTRL_RST, "control reset");
		rdc(OFS_STAT, 16'hffff, 16'h0000, "status reset");
		rdc(OFS_BAUD, 16'hffff, {7'h00, BAUD_RST}, "baud reset");
		rdc(3'h6, 16'hffff, 16'h0000, "unmapped read");
		chk({14'h0, sda_oe, scl_oe}, 16'h0000, "pins released at reset");
		chk({14'h0, sda_out, scl_out}, 16'h0000, "open drain drives low only");
		$display("reset test done");
		wr(OFS_TXH, 16'h0055);
		chk({15'h0, tx_start}, 16'h0001, "tx start pulse");
		chk({8'h0, tx_holding_reg}, 16'h0055, "tx byte taken");
		rdc(OFS_STAT, 16'h0001, 16'h0001, "tx full set");
		tx_done <= 1'b1;
		@(posedge mclk);
		tx_done <= 1'b0;
		rdc(OFS_STAT, 16'h0001, 16'h0000, "tx full cleared");
		tx_busy <= 1'b1;
		wr(OFS_TXH, 16'h0033);
		tx_busy <= 1'b0;
		chk({8'h0, tx_holding_reg}, 16'h0055, "busy write dropped");
		rdc(OFS_STAT, 16'h0081, 16'h0080, "clash set");
		rdc(OFS_STAT, 16'h0080, 16'h0080, "clash stays");
		wr(OFS_STAT, 16'h0000);
		rdc(OFS_STAT, 16'h0080, 16'h0000, "clash cleared");
		rx_byte_in <= 8'ha5;
		rx_load <= 1'b1;
		@(posedge mclk);
		rx_load <= 1'b0;
		rdc(OFS_STAT, 16'h0002, 16'h0002, "rx full set");
		rdc(OFS_RXH, 16'hffff, 16'h00a5, "rx byte");
		rdc(OFS_STAT, 16'h0002, 16'h0000, "rx full cleared");
		$display("holding register test done");
		// Master start with a long reload so the locked writes land inside it
		wr(OFS_BAUD, 16'h0014);
		wr(OFS_CTRL, 16'h8000);
		rdc(OFS_STAT, 16'h0010, 16'h0000, "bus not idle yet");
		m0 = n_mirq;
		wr(OFS_CTRL, 16'h8001);
		wr(OFS_TXH, 16'h00aa);
		wr(OFS_CTRL, 16'h8010);
		chk({11'h0, control_reg[4:0]}, 16'h0001, "request bits locked");
		chk({14'h0, sda_oe, scl_oe}, 16'h0000, "counting before data low");
		t = 0;
		while (sda_oe !== 1'b1 && t < 100) begin
			@(posedge mclk);
			#1;
			t++;
		end
		chk({15'h0, scl_oe}, 16'h0000, "data falls first");
		t = 0;
		while (scl_oe !== 1'b1 && t < 100) begin
			@(posedge mclk);
			#1;
			t++;
		end
		chk({15'h0, t >= 20 && t <= 22}, 16'h0001, "second interval length");
		chk({14'h0, sda_oe, control_reg[0]}, 16'h0002, "start ends, lines low");
		repeat (2) @(posedge mclk);
		chk(16'(n_mirq - m0), 16'h0001, "master event on start");
		rdc(OFS_STAT, 16'h0098, 16'h0088, "own start seen, clash");
		$display("start test done");
		for (int k = 0; k < 5; k++) begin
			m0 = n_mirq;
			pulse(k);
			chk(16'(n_mirq - m0), 16'h0001, "master event on completion");
		end
		wr(OFS_CTRL, 16'h0000);
		repeat (2) @(posedge mclk);
		chk({14'h0, sda_oe, scl_oe}, 16'h0000, "off releases pins");
		wr(OFS_CTRL, 16'h8080);
		wr(OFS_OWN, 16'h002a);
		repeat (3) @(posedge mclk);
		#1;
		chk({14'h0, sda_oe, scl_oe}, 16'h0000, "enable leaves bus idle");
		u_peer.stop_cond();
		rdc(OFS_STAT, 16'h0018, 16'h0010, "idle stop seen");
		u_peer.start_cond();
		rdc(OFS_STAT, 16'h0018, 16'h0008, "start seen");
		u_peer.stop_cond();
		rdc(OFS_STAT, 16'h0018, 16'h0010, "stop seen");
		$display("bus monitor test done");
		for (int k = 0; k < 4; k++) begin
			m0 = n_sirq;
			u_peer.start_cond();
			u_peer.send_byte(abyte[k]);
			u_peer.send_byte(8'hc3);
			repeat (10) @(posedge mclk);
			chk(16'(n_sirq - m0), 16'(aexp[k]), "slave events");
			if (aexp[k] > 0) rdc(OFS_STAT, 16'h0004, {13'h0, abyte[k][0], 2'h0}, "dir");
			if (aexp[k] > 0) rdc(OFS_RXH, 16'h00ff, {8'h00, rxexp[k]}, "slave byte");
			u_peer.stop_cond();
		end
		$display("slave test done");
		report_and_stop();
	end
endmodule // testbench
